// ==== pkg/host_port_pkg.sv ====
// constants for the dual-style host bus port of a two-channel uart
// assumes one 10 MHz core clock; bus pins already synchronous to it
package host_port_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_REGS = 8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int unsigned CTRL_IRQ_EN_BIT = 3;
    localparam logic [2:0] CTRL_ADDR = 3'h4;
    localparam logic CHAN_A = 1'b0;
    localparam logic CHAN_B = 1'b1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } bus_state_e;
endpackage : host_port_pkg

// ==== design/chan_regs.sv ====
// one channel's register bank plus its irq/aux/ready pin logic
// assumes writes arrive as single-cycle strobes from the bus front end
`timescale 1ns/1ns
module chan_regs #(
    parameter int unsigned NREG = host_port_pkg::NUM_REGS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic out2_o,
    input wire logic tx_space_i,
    input wire logic rx_avail_i,
    output logic tx_ready_n_o,
    output logic rx_ready_n_o
);
    logic [7:0] regs_q [NREG];
    logic [7:0] regs_d [NREG];
    logic tx_rdy_n_q, tx_rdy_n_d, rx_rdy_n_q, rx_rdy_n_d;

    // next register contents and ready levels
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
        begin
            regs_d[i] = regs_q[i];
        end
        if (wr_i)
        begin
            regs_d[addr_i] = wdata_i;
        end
        tx_rdy_n_d = ~tx_space_i;
        rx_rdy_n_d = ~rx_avail_i;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_q[i] <= host_port_pkg::REG_RESET;
            end
            tx_rdy_n_q <= 1'b1;
            rx_rdy_n_q <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_q[i] <= regs_d[i];
            end
            tx_rdy_n_q <= tx_rdy_n_d;
            rx_rdy_n_q <= rx_rdy_n_d;
        end
    end

    assign rdata_o = regs_q[addr_i];
    // cleared bit is the default, so irq starts tri-stated, except pin A in line style, which is not gated by it
    assign out2_o = regs_q[host_port_pkg::CTRL_ADDR][host_port_pkg::CTRL_IRQ_EN_BIT];
    assign tx_ready_n_o = tx_rdy_n_q;
    assign rx_ready_n_o = rx_rdy_n_q;
endmodule : chan_regs

// ==== design/dual_style_host_bus_port.sv ====
// host bus port of a two-channel uart: strobe style or read/write-line style
// assumes bus pins are synchronous to clk_i; the uart core supplies irq and fifo levels
`timescale 1ns/1ns
module dual_style_host_bus_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic strobe_style_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic chan_a_select_n_i,
    input wire logic chan_b_select_n_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic chan_a_irq_req_i,
    input wire logic chan_b_irq_req_i,
    input wire logic chan_a_tx_space_i,
    input wire logic chan_a_rx_avail_i,
    input wire logic chan_b_tx_space_i,
    input wire logic chan_b_rx_avail_i,
    output logic chan_a_irq_o,
    output logic chan_a_irq_oe_o,
    output logic chan_b_irq_o,
    output logic chan_b_irq_oe_o,
    output logic chan_a_aux_out_n_o,
    output logic chan_b_aux_out_n_o,
    output logic chan_a_tx_ready_n_o,
    output logic chan_a_rx_ready_n_o,
    output logic chan_b_tx_ready_n_o,
    output logic chan_b_rx_ready_n_o
);
    host_port_pkg::bus_state_e state_q, state_d;
    logic chan_q, chan_d;
    logic [2:0] addr_q, addr_d;
    logic [7:0] rd_q, rd_d;
    logic oe_q, oe_d;
    logic wr_a, wr_b;
    logic sel_a, sel_b, any_sel, rd_req, wr_req, strobe_rd, strobe_wr;
    logic [7:0] rdata_a, rdata_b;
    logic out2_a, out2_b;

    // decode of the two bus styles into one select/direction view
    always_comb
    begin
        if (strobe_style_i)
        begin
            sel_a = ~chan_a_select_n_i;
            sel_b = ~chan_b_select_n_i;
            strobe_rd = ~read_strobe_n_i;
            strobe_wr = ~write_strobe_n_i;
        end
        else
        begin
            // read strobe not looked at in this style
            sel_a = ~chan_a_select_n_i & ~chan_b_select_n_i;
            sel_b = ~chan_a_select_n_i & chan_b_select_n_i;
            strobe_rd = write_strobe_n_i;
            strobe_wr = ~write_strobe_n_i;
        end
        any_sel = sel_a | sel_b;
        // both strobes low at once is illegal; read wins to avoid a corrupt write
        rd_req = any_sel & strobe_rd;
        wr_req = any_sel & strobe_wr & ~strobe_rd;
    end

    // access sequencer: start on select plus strobe, finish when it goes away
    always_comb
    begin
        state_d = state_q;
        chan_d = chan_q;
        addr_d = addr_q;
        rd_d = rd_q;
        oe_d = 1'b0;
        wr_a = 1'b0;
        wr_b = 1'b0;
        case (state_q)
            host_port_pkg::ST_IDLE:
            begin
                chan_d = sel_b ? host_port_pkg::CHAN_B : host_port_pkg::CHAN_A;
                addr_d = reg_addr_i;
                if (rd_req)
                begin
                    state_d = host_port_pkg::ST_READ;
                end
                else if (wr_req)
                begin
                    state_d = host_port_pkg::ST_WRITE;
                    // take the byte now too, so a one-cycle strobe still stores fresh data
                    rd_d = data_i;
                end
            end
            host_port_pkg::ST_READ:
            begin
                rd_d = (chan_q == host_port_pkg::CHAN_B) ? rdata_b : rdata_a;
                oe_d = rd_req;
                if (!rd_req)
                begin
                    state_d = host_port_pkg::ST_IDLE;
                end
            end
            host_port_pkg::ST_WRITE:
            begin
                // the byte is latched when the strobe or select ends
                if (!wr_req)
                begin
                    wr_a = (chan_q == host_port_pkg::CHAN_A);
                    wr_b = (chan_q == host_port_pkg::CHAN_B);
                    state_d = host_port_pkg::ST_IDLE;
                end
                else
                begin
                    rd_d = data_i; // last byte seen while strobe low
                end
            end
            default:
            begin
                state_d = host_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= host_port_pkg::ST_IDLE;
            chan_q <= host_port_pkg::CHAN_A;
            addr_q <= 3'h0;
            rd_q <= host_port_pkg::REG_RESET;
            oe_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            chan_q <= chan_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
        end
    end

    assign data_o = rd_q;
    assign data_oe_o = oe_q;

    chan_regs u_chan_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_a),
        .addr_i(addr_q),
        .wdata_i(rd_q),
        .rdata_o(rdata_a),
        .out2_o(out2_a),
        .tx_space_i(chan_a_tx_space_i),
        .rx_avail_i(chan_a_rx_avail_i),
        .tx_ready_n_o(chan_a_tx_ready_n_o),
        .rx_ready_n_o(chan_a_rx_ready_n_o)
    );

    chan_regs u_chan_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_b),
        .addr_i(addr_q),
        .wdata_i(rd_q),
        .rdata_o(rdata_b),
        .out2_o(out2_b),
        .tx_space_i(chan_b_tx_space_i),
        .rx_avail_i(chan_b_rx_avail_i),
        .tx_ready_n_o(chan_b_tx_ready_n_o),
        .rx_ready_n_o(chan_b_rx_ready_n_o)
    );

    // interrupt and aux pins; the line style merges both channels on pin A
    always_comb
    begin
        chan_a_aux_out_n_o = ~out2_a;
        chan_b_aux_out_n_o = ~out2_b;
        chan_b_irq_o = chan_b_irq_req_i;
        chan_b_irq_oe_o = out2_b;
        if (strobe_style_i)
        begin
            chan_a_irq_o = chan_a_irq_req_i;
            chan_a_irq_oe_o = out2_a;
        end
        else
        begin
            // open drain: only ever drives low, pull-up makes the high
            chan_a_irq_o = 1'b0;
            chan_a_irq_oe_o = chan_a_irq_req_i | chan_b_irq_req_i;
        end
    end
endmodule : dual_style_host_bus_port

// ==== tb/host_port_asserts.sv ====
// port checker for the dual-style host bus port
// assumes the bench keeps one access at a time with idle gaps
`timescale 1ns/1ns
module host_port_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic strobe_style_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic chan_a_select_n_i,
    input wire logic data_oe_o,
    input wire logic chan_a_irq_req_i,
    input wire logic chan_b_irq_req_i,
    input wire logic chan_a_tx_space_i,
    input wire logic chan_b_rx_avail_i,
    input wire logic chan_a_irq_o,
    input wire logic chan_a_irq_oe_o,
    input wire logic chan_b_irq_oe_o,
    input wire logic chan_a_aux_out_n_o,
    input wire logic chan_b_aux_out_n_o,
    input wire logic chan_a_tx_ready_n_o,
    input wire logic chan_b_rx_ready_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read request steps in each bus style, and a quiet-irq step for the line style
    sequence rd_strobe;
        strobe_style_i && !read_strobe_n_i && !chan_a_select_n_i;
    endsequence
    sequence rd_line;
        !strobe_style_i && write_strobe_n_i && !chan_a_select_n_i;
    endsequence
    sequence quiet_line;
        !strobe_style_i && $stable(chan_a_irq_req_i) && $stable(chan_b_irq_req_i);
    endsequence
    a_read_answer: assert property ($fell(read_strobe_n_i) ##0 rd_strobe[*4] |-> data_oe_o)
        else $error("read answer missing");
    a_line_answer: assert property ($fell(chan_a_select_n_i) ##0 rd_line[*4] |-> data_oe_o)
        else $error("line read answer missing");
    a_oe_drop: assert property ($rose(read_strobe_n_i) && strobe_style_i |-> ##2 !data_oe_o)
        else $error("bus still driven after read");
    a_write_no_oe: assert property (
        (strobe_style_i && !write_strobe_n_i && read_strobe_n_i)[*3] |-> !data_oe_o)
        else $error("bus driven during write");
    a_line_irq: assert property (quiet_line[*2] |->
        !chan_a_irq_o && (chan_a_irq_oe_o == (chan_a_irq_req_i || chan_b_irq_req_i)))
        else $error("merged interrupt wrong");
    a_irq_a_pair: assert property (strobe_style_i && $stable(strobe_style_i) |->
        chan_a_irq_oe_o != chan_a_aux_out_n_o)
        else $error("irq a enable and aux a disagree");
    a_irq_b_pair: assert property (chan_b_irq_oe_o != chan_b_aux_out_n_o)
        else $error("irq b enable and aux b disagree");
    a_ready_lag: assert property (!$past(rst_i) |->
        chan_a_tx_ready_n_o == !$past(chan_a_tx_space_i) && chan_b_rx_ready_n_o == !$past(chan_b_rx_avail_i))
        else $error("ready outputs wrong");
endmodule : host_port_asserts
bind dual_style_host_bus_port host_port_asserts u_chk (.clk_i, .rst_i, .strobe_style_i, .read_strobe_n_i,
    .write_strobe_n_i, .chan_a_select_n_i, .data_oe_o, .chan_a_irq_req_i, .chan_b_irq_req_i, .chan_a_tx_space_i,
    .chan_b_rx_avail_i, .chan_a_irq_o, .chan_a_irq_oe_o, .chan_b_irq_oe_o, .chan_a_aux_out_n_o,
    .chan_b_aux_out_n_o, .chan_a_tx_ready_n_o, .chan_b_rx_ready_n_o);

// ==== tb/host_model.sv ====
// host processor model driving the bus pins of the port
// assumes the bench resolves the shared data wire from data_oe_o
`timescale 1ns/1ns
module host_model (
    input wire logic clk_i,
    input wire logic style_i,
    input wire logic [7:0] rdata_i,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic csa_n_o,
    output logic csb_n_o,
    output logic [2:0] addr_o,
    output logic [7:0] wdata_o
);
    initial
    begin
        {rd_n_o, wr_n_o, csa_n_o, csb_n_o, addr_o, wdata_o} = 15'h7800;
    end
    // one byte; held four edges so the registered answer has landed
    task automatic access(input logic wr, input logic ch, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_n_o <= !wr;
        csb_n_o <= style_i ? !ch : ch;
        csa_n_o <= style_i ? ch : 1'b0;
        rd_n_o <= style_i ? wr : 1'b1;
        repeat (4) @(posedge clk_i);
        q = rdata_i;
        {rd_n_o, wr_n_o, csa_n_o, csb_n_o} <= 4'hF;
        wdata_o <= ~d; // released bus must not keep the stale byte
        repeat (2) @(posedge clk_i);
    endtask : access
endmodule : host_model

// ==== tb/dual_style_host_bus_port_tb.sv ====
// self-checking bench for the dual-style host bus port
// assumes one clock; host_model owns the bus pins
`timescale 1ns/1ns
module dual_style_host_bus_port_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic style = 1'b1;
    logic [1:0] req = 2'h0;
    logic [3:0] stat = 4'h0;
    logic rd_n, wr_n, csa_n, csb_n, oe, ia, ia_oe, ib, ib_oe, xa_n, xb_n;
    logic [3:0] rdy_n;
    logic [2:0] addr;
    logic [7:0] wdata, dout, bus, q;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk_i = ~clk_i;
    assign bus = oe ? dout : wdata;
    dual_style_host_bus_port DUT (.clk_i(clk_i), .rst_i(rst_i), .strobe_style_i(style), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .chan_a_select_n_i(csa_n), .chan_b_select_n_i(csb_n), .reg_addr_i(addr),
        .data_i(bus), .data_o(dout), .data_oe_o(oe), .chan_a_irq_req_i(req[0]), .chan_b_irq_req_i(req[1]),
        .chan_a_tx_space_i(stat[3]), .chan_a_rx_avail_i(stat[2]), .chan_b_tx_space_i(stat[1]),
        .chan_b_rx_avail_i(stat[0]), .chan_a_irq_o(ia), .chan_a_irq_oe_o(ia_oe), .chan_b_irq_o(ib),
        .chan_b_irq_oe_o(ib_oe), .chan_a_aux_out_n_o(xa_n), .chan_b_aux_out_n_o(xb_n),
        .chan_a_tx_ready_n_o(rdy_n[3]), .chan_a_rx_ready_n_o(rdy_n[2]), .chan_b_tx_ready_n_o(rdy_n[1]),
        .chan_b_rx_ready_n_o(rdy_n[0]));
    host_model host (.clk_i(clk_i), .style_i(style), .rdata_i(bus), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .csa_n_o(csa_n), .csb_n_o(csb_n), .addr_o(addr), .wdata_o(wdata));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    // per-channel writes then read-back; control bit 3 gates irq and aux
    task automatic t_strobe();
        for (int c = 0; c < 2; c++)
        begin
            host.access(1'b1, 1'(c), host_port_pkg::CTRL_ADDR, 8'h08, q);
            host.access(1'b1, 1'(c), 3'h7, 8'hA0 + 8'(c), q);
        end
        for (int c = 0; c < 2; c++)
        begin
            host.access(1'b0, 1'(c), 3'h7, 8'h00, q);
            check("strobe_read", q, 8'hA0 + 8'(c));
        end
        check("aux_set", {4'h0, xa_n, xb_n, ia_oe, ib_oe}, 8'h03);
        host.access(1'b1, 1'b0, host_port_pkg::CTRL_ADDR, 8'h00, q);
        check("aux_clear", {4'h0, xa_n, xb_n, ia_oe, ib_oe}, 8'h09);
    endtask : t_strobe
    // irq value follows the core request whether or not enabled; the enable only gates the driver
    task automatic t_irq();
        req <= 2'h3;
        repeat (3) @(posedge clk_i);
        check("irq_b", {4'h0, ia, ib, ib_oe, ia_oe}, 8'h0E);
    endtask : t_irq
    task automatic t_ready();
        for (int p = 0; p < 2; p++)
        begin
            stat <= p ? 4'h5 : 4'hA;
            repeat (3) @(posedge clk_i);
            check("ready", {4'h0, rdy_n}, p ? 8'h0A : 8'h05);
        end
    endtask : t_ready
    // line style: pick bit routes channel, pin A carries merged irq
    task automatic t_line();
        style <= 1'b0;
        req <= 2'h2;
        host.access(1'b1, 1'b1, 3'h2, 8'h3C, q);
        host.access(1'b1, 1'b0, 3'h2, 8'hC3, q);
        host.access(1'b0, 1'b1, 3'h2, 8'h00, q);
        check("line_b", q, 8'h3C);
        host.access(1'b0, 1'b0, 3'h2, 8'h00, q);
        check("line_a", q, 8'hC3);
        check("merged_irq", {6'h00, ia, ia_oe}, 8'h01);
    endtask : t_line
    initial
    begin
        repeat (5) @(posedge clk_i);
        check("reset_outs", {4'h0, oe, xa_n, xb_n, rdy_n[3]}, 8'h07);
        rst_i <= 1'b0;
        t_strobe();
        t_irq();
        t_ready();
        t_line();
        results();
    end
    // hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            fails++;
            results();
        end
    end
endmodule : dual_style_host_bus_port_tb
